// ==== rtl/converter_setting_pkg.sv ====
// constants and carrier types for the converter setting registers
package converter_setting_pkg;

    // ****************************************
    // register map
    // ****************************************
    localparam logic [7:0] ADDR_POWER_CONTROL = 8'h0e;
    localparam logic [7:0] ADDR_LOOP_TUNING = 8'h0f;
    localparam logic [7:0] ADDR_MONITOR_SERIAL = 8'h10;

    localparam logic [7:0] RST_POWER_CONTROL = 8'h10;
    localparam logic [7:0] RST_LOOP_TUNING = 8'h10;
    localparam logic [7:0] RST_MONITOR_SERIAL = 8'h82;

    // writable bits, reserved ones cleared
    localparam logic [7:0] WMASK_POWER_CONTROL = 8'hf7;
    localparam logic [7:0] WMASK_LOOP_TUNING = 8'hff;
    localparam logic [7:0] WMASK_MONITOR_SERIAL = 8'hf3;

    // ****************************************
    // field positions
    // ****************************************
    localparam int POS_RUN = 7;
    localparam int POS_IV_LOOP_OFF = 6;
    localparam int POS_IC_LOOP_OFF = 5;
    localparam int POS_BLEED = 4;
    localparam int POS_CABLE = 0;
    localparam int POS_DEAD_TIME = 6;
    localparam int POS_GM = 4;
    localparam int POS_IN_GAIN = 2;
    localparam int POS_OUT_GAIN = 0;
    localparam int POS_AVG = 6;
    localparam int POS_RATE = 5;
    localparam int POS_OCP_X10 = 4;
    localparam int POS_CONV_EN = 1;
    localparam int POS_DRV_CHARGE = 0;

    // cable compensation in milliohm by code
    localparam logic [7:0] CABLE_MOHM [8] = '{8'h00, 8'h0a, 8'h14, 8'h28,
                                              8'h50, 8'h78, 8'ha0, 8'hc8};

    // ****************************************
    // serial slave states, gray along the write path, not at the ST_ADDR_ACK to ST_RDATA step
    // ****************************************
    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_ADDR = 4'h1,
        ST_ADDR_ACK = 4'h3,
        ST_PTR = 4'h2,
        ST_PTR_ACK = 4'h6,
        ST_WDATA = 4'h7,
        ST_WDATA_ACK = 4'h5,
        ST_RDATA = 4'h4,
        ST_RDATA_ACK = 4'hc
    } serial_state_e;

    typedef struct packed {
        logic converter_run;
        logic input_voltage_loop_on;
        logic input_current_loop_on;
        logic bleed_en;
        logic [2:0] cable_drop_comp_sel;
        logic [7:0] cable_comp_mohm;
        logic [1:0] gate_dead_time_sel;
        logic [1:0] loop_gm_sel;
        logic [1:0] input_sense_gain_sel;
        logic [1:0] output_sense_gain_sel;
        logic [1:0] conversion_average_sel;
        logic serial_rate_sel;
        logic ocp_delay_x10;
        logic monitor_conv_en;
        logic driver_charge_en;
    } converter_cfg_s;

endpackage

// ==== rtl/converter_setting_regs.sv ====
// serial-programmed converter setting registers with their serial slave
`timescale 1ns/1ps

module converter_setting_regs
    import converter_setting_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR = 7'h2c
) (
    // clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // serial pins
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // converter side
    input wire logic dvs_down,
    output converter_cfg_s cfg,
    output logic bleed_on,
    output logic power_direction_wr_ok
);

    if (DEV_ADDR == 7'h00) begin : g_bad_addr
        $error("device address 0 is the general call address");
    end

    // ****************************************
    // pin synchronisers and bus events
    // ****************************************
    logic [1:0] scl_sync;
    logic [1:0] sda_sync;
    logic scl_d;
    logic sda_d;

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            scl_sync <= 2'h3;
            sda_sync <= 2'h3;
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            scl_sync <= {scl_sync[0], scl_in};
            sda_sync <= {sda_sync[0], sda_in};
            scl_d <= scl_sync[1];
            sda_d <= sda_sync[1];
        end
    end

    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;

    assign scl_rise = scl_sync[1] & ~scl_d;
    assign scl_fall = ~scl_sync[1] & scl_d;
    assign bus_start = scl_sync[1] & scl_d & sda_d & ~sda_sync[1];
    assign bus_stop = scl_sync[1] & scl_d & ~sda_d & sda_sync[1];

    // ****************************************
    // registers
    // ****************************************
    logic [7:0] power_control_cfg;
    logic [7:0] loop_tuning_cfg;
    logic [7:0] monitor_serial_cfg;

    function automatic logic [7:0] read_reg(input logic [7:0] addr, input logic [7:0] pc,
                                            input logic [7:0] lt, input logic [7:0] ms);
        logic [7:0] v;
        v = 8'h00;
        unique case (addr)
            ADDR_POWER_CONTROL: v = pc;
            ADDR_LOOP_TUNING: v = lt;
            ADDR_MONITOR_SERIAL: v = ms;
            default: v = 8'h00;
        endcase
        return v;
    endfunction

    // ****************************************
    // serial slave
    // ****************************************
    serial_state_e state;
    logic [7:0] shift;
    logic [3:0] bit_cnt;
    logic [7:0] ptr;
    logic read_mode;
    logic nack_seen;
    logic wr_stb;

    assign wr_stb = (state == ST_WDATA) && scl_fall && (bit_cnt == 4'h8);

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            state <= ST_IDLE;
            shift <= 8'h00;
            bit_cnt <= 4'h0;
            ptr <= 8'h00;
            read_mode <= 1'b0;
            nack_seen <= 1'b0;
        end else if (bus_start) begin
            state <= ST_ADDR;
            bit_cnt <= 4'h0;
        end else if (bus_stop) begin
            state <= ST_IDLE;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    bit_cnt <= 4'h0;
                end
                ST_ADDR, ST_PTR, ST_WDATA: begin
                    if (scl_rise) begin
                        shift <= {shift[6:0], sda_sync[1]};
                        bit_cnt <= bit_cnt + 4'h1;
                    end else if (scl_fall && bit_cnt == 4'h8) begin
                        if (state == ST_ADDR) begin
                            read_mode <= shift[0];
                            state <= (shift[7:1] == DEV_ADDR) ? ST_ADDR_ACK : ST_IDLE;
                        end else if (state == ST_PTR) begin
                            ptr <= shift;
                            state <= ST_PTR_ACK;
                        end else begin
                            ptr <= ptr + 8'h01;
                            state <= ST_WDATA_ACK;
                        end
                    end
                end
                ST_ADDR_ACK, ST_PTR_ACK, ST_WDATA_ACK: begin
                    if (scl_fall) begin
                        bit_cnt <= 4'h0;
                        if (state == ST_ADDR_ACK && read_mode) begin
                            shift <= read_reg(ptr, power_control_cfg, loop_tuning_cfg,
                                              monitor_serial_cfg);
                            state <= ST_RDATA;
                        end else begin
                            state <= (state == ST_ADDR_ACK) ? ST_PTR : ST_WDATA;
                        end
                    end
                end
                ST_RDATA: begin
                    if (scl_fall) begin
                        shift <= {shift[6:0], 1'b0};
                        bit_cnt <= bit_cnt + 4'h1;
                        if (bit_cnt == 4'h7) begin
                            ptr <= ptr + 8'h01;
                            state <= ST_RDATA_ACK;
                        end
                    end
                end
                ST_RDATA_ACK: begin
                    if (scl_rise) begin
                        nack_seen <= sda_sync[1];
                    end else if (scl_fall) begin
                        bit_cnt <= 4'h0;
                        shift <= read_reg(ptr, power_control_cfg, loop_tuning_cfg,
                                          monitor_serial_cfg);
                        state <= nack_seen ? ST_IDLE : ST_RDATA;
                    end
                end
            endcase
        end
    end

    // open drain: only ever pulls low
    assign sda_out = 1'b0;
    assign sda_oe = (state == ST_ADDR_ACK) || (state == ST_PTR_ACK) ||
                    (state == ST_WDATA_ACK) || ((state == ST_RDATA) && !shift[7]);

    // ****************************************
    // register writes
    // ****************************************
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            power_control_cfg <= RST_POWER_CONTROL;
            loop_tuning_cfg <= RST_LOOP_TUNING;
            monitor_serial_cfg <= RST_MONITOR_SERIAL;
        end else if (wr_stb) begin
            if (ptr == ADDR_POWER_CONTROL) begin
                power_control_cfg <= shift & WMASK_POWER_CONTROL;
            end
            if (ptr == ADDR_LOOP_TUNING) begin
                loop_tuning_cfg <= shift & WMASK_LOOP_TUNING;
            end
            if (ptr == ADDR_MONITOR_SERIAL) begin
                monitor_serial_cfg <= shift & WMASK_MONITOR_SERIAL;
            end
        end
    end

    // ****************************************
    // converter controls
    // ****************************************
    assign cfg.converter_run = power_control_cfg[POS_RUN];
    assign cfg.input_voltage_loop_on = ~power_control_cfg[POS_IV_LOOP_OFF];
    assign cfg.input_current_loop_on = ~power_control_cfg[POS_IC_LOOP_OFF];
    assign cfg.bleed_en = power_control_cfg[POS_BLEED];
    assign cfg.cable_drop_comp_sel = power_control_cfg[POS_CABLE +: 3];
    assign cfg.cable_comp_mohm = CABLE_MOHM[power_control_cfg[POS_CABLE +: 3]];
    assign cfg.gate_dead_time_sel = loop_tuning_cfg[POS_DEAD_TIME +: 2];
    assign cfg.loop_gm_sel = loop_tuning_cfg[POS_GM +: 2];
    assign cfg.input_sense_gain_sel = loop_tuning_cfg[POS_IN_GAIN +: 2];
    assign cfg.output_sense_gain_sel = loop_tuning_cfg[POS_OUT_GAIN +: 2];
    assign cfg.conversion_average_sel = monitor_serial_cfg[POS_AVG +: 2];
    assign cfg.serial_rate_sel = monitor_serial_cfg[POS_RATE];
    assign cfg.ocp_delay_x10 = monitor_serial_cfg[POS_OCP_X10];
    assign cfg.monitor_conv_en = monitor_serial_cfg[POS_CONV_EN];
    assign cfg.driver_charge_en = monitor_serial_cfg[POS_DRV_CHARGE];

    assign bleed_on = cfg.bleed_en & (~cfg.converter_run | dvs_down);
    assign power_direction_wr_ok = ~cfg.converter_run;

    // ****************************************
    // assertions
    // ****************************************
    a_run_write: assert property (@(posedge mclk) disable iff (sys_rst)
        wr_stb && ptr == ADDR_POWER_CONTROL |=> cfg.converter_run == $past(shift[7]))
        else $error("run bit did not take written value");

    a_iv_loop_write: assert property (@(posedge mclk) disable iff (sys_rst)
        wr_stb && ptr == ADDR_POWER_CONTROL |=> cfg.input_voltage_loop_on != $past(shift[6]))
        else $error("voltage loop state wrong after write");

    a_bleed_cause: assert property (@(posedge mclk) disable iff (sys_rst)
        bleed_on |-> cfg.bleed_en && (!cfg.converter_run || dvs_down))
        else $error("bleed on without cause");

    a_cable_top: assert property (@(posedge mclk) disable iff (sys_rst)
        cfg.cable_drop_comp_sel == 3'h7 |-> cfg.cable_comp_mohm == 8'hc8)
        else $error("cable code 7 not 200 milliohm");

    a_dead_reset: assert property (@(posedge mclk) disable iff (sys_rst)
        $past(sys_rst) |-> cfg.gate_dead_time_sel == 2'h0)
        else $error("dead time not 00 after reset");

    a_gain_reset: assert property (@(posedge mclk) disable iff (sys_rst)
        $past(sys_rst) |-> cfg.input_sense_gain_sel == 2'h0)
        else $error("input gain not 00 after reset");

    a_avg_reset: assert property (@(posedge mclk) disable iff (sys_rst)
        $past(sys_rst) |-> cfg.conversion_average_sel == 2'h2 && cfg.monitor_conv_en)
        else $error("monitor setting wrong after reset");

    a_monitor_write: assert property (@(posedge mclk) disable iff (sys_rst)
        wr_stb && ptr == ADDR_MONITOR_SERIAL |=>
            {cfg.monitor_conv_en, cfg.driver_charge_en, cfg.serial_rate_sel} ==
            {$past(shift[1]), $past(shift[0]), $past(shift[5])})
        else $error("monitor bits did not take written value");

    a_reserved_zero: assert property (@(posedge mclk) disable iff (sys_rst)
        power_control_cfg[3] == 1'b0 && monitor_serial_cfg[3:2] == 2'h0)
        else $error("reserved bit holds a one");

endmodule

// ==== tb/i2c_host_model.sv ====
// serial bus host model that programs the converter setting registers
`timescale 1ns/1ps

module i2c_host_model (
    // clock
    input wire logic mclk,
    // bus lines
    input wire logic sda,
    output logic scl,
    output logic sda_pull
);
    localparam int HALF = 8;

    // bus idles released, clock parked high
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    // one clock pulse, data moves mid-low, sampled mid-high
    task automatic pulse(output logic seen);
        wait_clk(HALF / 2);
        scl = 1'b1;
        wait_clk(HALF / 2);
        seen = sda;
        wait_clk(HALF / 2);
        scl = 1'b0;
        wait_clk(HALF / 2);
    endtask

    // start or repeated start
    task automatic start;
        sda_pull = 1'b0;
        wait_clk(HALF / 2);
        scl = 1'b1;
        wait_clk(HALF);
        sda_pull = 1'b1;
        wait_clk(HALF);
        scl = 1'b0;
        wait_clk(HALF / 2);
    endtask

    task automatic stop;
        sda_pull = 1'b1;
        wait_clk(HALF / 2);
        scl = 1'b1;
        wait_clk(HALF);
        sda_pull = 1'b0;
        wait_clk(HALF);
    endtask

    task automatic write_byte(input logic [7:0] b, output logic ack);
        logic x;
        for (int i = 7; i >= 0; i--) begin
            sda_pull = ~b[i];
            pulse(x);
        end
        sda_pull = 1'b0;
        pulse(x);
        ack = ~x;
    endtask

    task automatic read_byte(output logic [7:0] b, input logic last);
        logic x;
        sda_pull = 1'b0;
        for (int i = 7; i >= 0; i--) begin
            pulse(x);
            b[i] = x;
        end
        sda_pull = ~last;
        pulse(x);
        sda_pull = 1'b0;
    endtask
endmodule

// ==== tb/tb.sv ====
// self-checking bench for the converter setting registers
`timescale 1ns/1ps

`define CHK(got, exp) \
    begin n_compared++; if ((got) !== (exp)) begin miscompares++; \
    $display("BAD %0t mismatch got %h exp %h", $time, got, exp); end end

module tb import converter_setting_pkg::*; ;
    localparam logic [6:0] SLAVE = 7'h2c;
    logic mclk;
    logic sys_rst;
    logic scl;
    logic sda;
    logic host_pull;
    logic sda_out;
    logic sda_oe;
    logic dvs_down;
    converter_cfg_s cfg;
    logic bleed_on;
    logic power_direction_wr_ok;
    int miscompares = 0;
    int n_compared = 0;

    // open-drain wire with pull-up
    assign sda = ~((sda_oe & ~sda_out) | host_pull);

    converter_setting_regs #(.DEV_ADDR(SLAVE)) dut (.mclk(mclk), .sys_rst(sys_rst),
        .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
        .dvs_down(dvs_down), .cfg(cfg), .bleed_on(bleed_on),
        .power_direction_wr_ok(power_direction_wr_ok));

    i2c_host_model host (.mclk(mclk), .sda(sda), .scl(scl), .sda_pull(host_pull));

    // ****************************************
    // bus access
    // ****************************************
    task automatic reg_wr(input logic [7:0] ptr, input logic [7:0] data);
        logic a0, a1, a2;
        host.start();
        host.write_byte({SLAVE, 1'b0}, a0);
        host.write_byte(ptr, a1);
        host.write_byte(data, a2);
        host.stop();
        `CHK({a0, a1, a2}, 3'b111);
    endtask

    // three bytes from ptr upward
    task automatic reg_rd(input logic [7:0] ptr, output logic [7:0] d [3]);
        logic a0, a1, a2;
        host.start();
        host.write_byte({SLAVE, 1'b0}, a0);
        host.write_byte(ptr, a1);
        host.start();
        host.write_byte({SLAVE, 1'b1}, a2);
        for (int i = 0; i < 3; i++) begin
            host.read_byte(d[i], i == 2);
        end
        host.stop();
        `CHK({a0, a1, a2}, 3'b111);
    endtask

    task automatic close_out;
        if (miscompares == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_reset;
        logic [7:0] d [3];
        `CHK(cfg.converter_run, 1'b0);
        `CHK(cfg.gate_dead_time_sel, 2'b00);
        `CHK(cfg.input_sense_gain_sel, 2'b00);
        `CHK(cfg.monitor_conv_en, 1'b1);
        `CHK(bleed_on, 1'b1);
        reg_rd(8'h0e, d);
        `CHK(d[0], 8'h10);
        `CHK(d[1], RST_LOOP_TUNING);
        `CHK(d[2], RST_MONITOR_SERIAL);
    endtask

    task automatic t_power;
        logic [7:0] d [3];
        reg_wr(8'h0e, 8'hff);
        reg_rd(8'h0e, d);
        `CHK(d[0], 8'hf7);
        `CHK({cfg.input_current_loop_on, cfg.bleed_en}, 2'b01);
        `CHK(cfg.converter_run, 1'b1);
        `CHK(cfg.input_voltage_loop_on, 1'b0);
        `CHK(power_direction_wr_ok, 1'b0);
        `CHK(bleed_on, 1'b0);
        dvs_down = 1'b1;
        host.wait_clk(1);
        `CHK(bleed_on, 1'b1);
        dvs_down = 1'b0;
        reg_wr(8'h0e, 8'h00);
        `CHK(cfg.converter_run, 1'b0);
        `CHK(cfg.input_voltage_loop_on, 1'b1);
        `CHK(power_direction_wr_ok, 1'b1);
        `CHK(bleed_on, 1'b0);
    endtask

    task automatic t_cable;
        logic [7:0] mohm [8] = '{8'h00, 8'h0a, 8'h14, 8'h28, 8'h50, 8'h78, 8'ha0, 8'hc8};
        for (int c = 0; c < 8; c++) begin
            reg_wr(8'h0e, 8'(c));
            `CHK(cfg.cable_drop_comp_sel, 3'(c));
            `CHK(cfg.cable_comp_mohm, mohm[c]);
        end
    endtask

    task automatic t_tuning;
        logic [7:0] d [3];
        reg_wr(8'h0f, 8'hc4);
        `CHK(cfg.gate_dead_time_sel, 2'b11);
        `CHK(cfg.input_sense_gain_sel, 2'b01);
        `CHK({cfg.loop_gm_sel, cfg.output_sense_gain_sel}, 4'h0);
        reg_rd(8'h0f, d);
        `CHK(d[0], 8'hc4);
        reg_wr(8'h0f, 8'h00);
        `CHK(cfg.gate_dead_time_sel, 2'b00);
        `CHK(cfg.input_sense_gain_sel, 2'b00);
    endtask

    task automatic t_monitor;
        logic [7:0] d [3];
        reg_wr(8'h10, 8'hff);
        reg_rd(8'h10, d);
        `CHK(d[0], 8'hf3);
        `CHK({d[1], d[2]}, 16'h0000);
        `CHK(cfg.ocp_delay_x10, 1'b1);
        `CHK(cfg.conversion_average_sel, 2'b11);
        `CHK(cfg.serial_rate_sel, 1'b1);
        `CHK(cfg.monitor_conv_en, 1'b1);
        `CHK(cfg.driver_charge_en, 1'b1);
        reg_wr(8'h10, 8'h0c);
        reg_rd(8'h10, d);
        `CHK(d[0], 8'h00);
        `CHK(cfg.conversion_average_sel, 2'b00);
        `CHK(cfg.serial_rate_sel, 1'b0);
        `CHK(cfg.monitor_conv_en, 1'b0);
        `CHK(cfg.driver_charge_en, 1'b0);
    endtask

    task automatic t_wrong_addr;
        logic a;
        host.start();
        host.write_byte({SLAVE + 7'h01, 1'b0}, a);
        host.stop();
        `CHK(a, 1'b0);
    endtask

    // read from the pointer left by the previous write
    task automatic t_cur_ptr;
        logic a;
        logic [7:0] d0;
        logic [7:0] d1;
        reg_wr(8'h0f, 8'h5a);
        reg_wr(8'h0e, 8'h15);
        `CHK(bleed_on, 1'b1);
        host.start();
        host.write_byte({SLAVE, 1'b1}, a);
        host.read_byte(d0, 1'b0);
        host.read_byte(d1, 1'b1);
        host.stop();
        `CHK(a, 1'b1);
        `CHK(d0, 8'h5a);
        `CHK(d1, 8'h00);
    endtask

    // ****************************************
    // clock, reset, sequence
    // ****************************************
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    initial begin
        repeat (60000) @(posedge mclk);
        miscompares++;
        close_out();
    end

    initial begin
        sys_rst = 1'b1;
        dvs_down = 1'b0;
        repeat (5) @(posedge mclk);
        #1;
        sys_rst = 1'b0;
        host.wait_clk(4);
        t_reset();
        t_power();
        t_cable();
        t_tuning();
        t_monitor();
        t_wrong_addr();
        t_cur_ptr();
        close_out();
    end
endmodule
